/* include/mfi_params.svh */
// constants for the microframe index and periodic list origin block
// assumes a 25 MHz core clock and a plain word register port
`ifndef MFI_PARAMS_SVH
`define MFI_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define MFI_OFS_INDEX    8'h2C
`define MFI_OFS_ORIGIN   8'h34
`define MFI_OFS_SEGMENT  8'h10

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define MFI_INDEX_W      14
`define MFI_ORIGIN_LSB   12
`define MFI_SOF_LSB      3
`define MFI_INDEX_RST    14'h0000
`define MFI_ORIGIN_RST   20'h00000
`define MFI_SEGMENT_RST  32'h00000000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MFI_CLK_MHZ      25
`define MFI_UFRAME_US    125
`define MFI_UFRAME_CYC   (`MFI_UFRAME_US * `MFI_CLK_MHZ)

`endif

/* include/mfi_pkg.sv */
// types for the microframe index block
// assumes mfi_params.svh for the figures
`default_nettype none
package mfi_pkg;

  // frame list size setting
  typedef enum logic [1:0] {
    MFI_LIST_1024 = 2'h0,
    MFI_LIST_512  = 2'h1,
    MFI_LIST_256  = 2'h2,
    MFI_LIST_RSVD = 2'h3
  } mfi_list_size_t;

  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mfi_req_t;

  // schedule walker outputs
  typedef struct packed {
    logic [63:0] entryAddr;
    logic [10:0] sofFrame;
    logic        entryStep;
  } mfi_walk_t;

  // microframe timer state
  typedef enum logic [0:0] {
    MFI_IDLE = 1'b0,
    MFI_RUN  = 1'b1
  } mfi_tstate_t;

endpackage
`default_nettype wire

/* core/mfi_uframe_timer.sv */
// microframe tick generator
// assumes run arrives synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "mfi_params.svh"
module mfi_uframe_timer
  import mfi_pkg::*;
#(
  parameter int unsigned CYCLES = `MFI_UFRAME_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  localparam int unsigned CW = $clog2(CYCLES);

  typedef struct packed {
    mfi_tstate_t   st;
    logic [CW-1:0] cnt;
    logic          tick;
  } mfi_tmr_t;

  mfi_tmr_t s_q, s_d;

  // ----------------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------------
  // one tick per microframe
  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    case (s_q.st)
      MFI_IDLE: begin
        s_d.cnt = '0;
        if (run) begin
          s_d.st = MFI_RUN;
        end
      end
      MFI_RUN: begin
        if (!run) begin
          s_d.st  = MFI_IDLE;
          s_d.cnt = '0;
        end else if (s_q.cnt == CW'(CYCLES - 1)) begin
          s_d.cnt  = '0;
          s_d.tick = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + CW'(1);
        end
      end
      default: s_d.st = MFI_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

  tick_spacing_a: assert property (@(posedge clk) disable iff (!rstn)
    tick |=> !tick [*2])
    else $error("microframe ticks too close");
endmodule
`default_nettype wire

/* core/mfi_list_walker.sv */
// forms the periodic list entry address and start-of-frame number
// assumes the next-state index and origin from the top module
`timescale 1ns/1ps
`default_nettype none
`include "mfi_params.svh"
module mfi_list_walker
  import mfi_pkg::*;
(
  input  wire logic [13:0] index,
  input  wire logic [19:0] origin,
  input  wire logic [31:0] segment,
  input  wire logic        wideAddr,
  input  wire logic [1:0]  listSize,
  output mfi_walk_t        walk
);
  logic [9:0] slot;

  // ----------------------------------------------------------------------
  // entry selection
  // ----------------------------------------------------------------------
  // slot from bits N..3
  always_comb begin
    case (mfi_list_size_t'(listSize))
      MFI_LIST_1024: slot = index[12:3];
      MFI_LIST_512:  slot = {1'b0, index[11:3]};
      MFI_LIST_256:  slot = {2'b00, index[10:3]};
      default:       slot = {2'b00, index[10:3]}; // reserved: smallest list
    endcase
  end

  always_comb begin
    walk.entryAddr = {wideAddr ? segment : 32'h00000000, origin, slot, 2'b00};
    walk.sofFrame  = index[13:`MFI_SOF_LSB];
    walk.entryStep = (index[2:0] == 3'h0);
  end
endmodule
`default_nettype wire

/* core/mfi_frame_index.sv */
// microframe index counter and periodic list origin register
// assumes run/halted/list size/wide addressing come from neighbour registers
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mfi_params.svh"
module mfi_frame_index
  import mfi_pkg::*;
#(
  parameter int unsigned UFRAME_CYC = `MFI_UFRAME_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        runStop,
  input  wire logic        haltedFlag,
  input  wire logic [1:0]  frameListSize,
  input  wire logic        wideAddressingCapable,
  output logic      [63:0] entryAddr,
  output logic      [10:0] sofFrame,
  output logic             sofStrobe,
  output logic             writeRefused
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [13:0] index;
    logic [19:0] origin;
    logic [31:0] segment;
    logic [31:0] rdata;
    logic [63:0] entryAddr;
    logic [10:0] sofFrame;
    logic        sofStrobe;
    logic        refused;
  } mfi_state_t;

  mfi_state_t s_q, s_d;
  mfi_walk_t  walk;
  mfi_walk_t  walkNext;
  logic       tick;
  mfi_req_t   req;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ----------------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------------
  // microframe timer runs only while the schedule runs
  mfi_uframe_timer #(
    .CYCLES (UFRAME_CYC)
  ) u_timer (
    .clk  (clk),
    .rstn (rstn),
    .run  (runStop),
    .tick (tick)
  );

  // entry address built from the next state so outputs are registered
  // walker result feeds the flops only, never the next-state logic: no loop
  mfi_list_walker u_walker (
    .index    (s_d.index),
    .origin   (s_d.origin),
    .segment  (s_d.segment),
    .wideAddr (wideAddressingCapable),
    .listSize (frameListSize),
    .walk     (walkNext)
  );

  assign walk = walkNext;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.rdata     = 32'h00000000;
    s_d.sofStrobe = 1'b0;
    s_d.refused   = 1'b0;

    if (tick) begin
      s_d.index     = s_q.index + 14'h0001;
      s_d.sofStrobe = 1'b1;
    end

    if (req.wr) begin
      case (req.addr)
        `MFI_OFS_INDEX: begin
          if (haltedFlag) begin
            s_d.index = req.wdata[`MFI_INDEX_W-1:0];
          end else begin
            s_d.refused = 1'b1;
          end
        end
        `MFI_OFS_ORIGIN:  s_d.origin  = req.wdata[31:`MFI_ORIGIN_LSB];
        `MFI_OFS_SEGMENT: s_d.segment = req.wdata;
        default: ;
      endcase
    end

    // read back with reserved bits zero
    if (req.rd) begin
      case (req.addr)
        `MFI_OFS_INDEX:   s_d.rdata = {18'h00000, s_q.index};
        `MFI_OFS_ORIGIN:  s_d.rdata = {s_q.origin, 12'h000};
        `MFI_OFS_SEGMENT: s_d.rdata = s_q.segment;
        default:          s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // reset to zero
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_q         <= '0;
      s_q.index   <= `MFI_INDEX_RST;
      s_q.origin  <= `MFI_ORIGIN_RST;
      s_q.segment <= `MFI_SEGMENT_RST;
    end else begin
      s_q           <= s_d;
      // walker fields land with their index
      s_q.entryAddr <= walk.entryAddr;
      s_q.sofFrame  <= walk.sofFrame;
    end
  end

  assign rdata        = s_q.rdata;
  assign entryAddr    = s_q.entryAddr;
  assign sofFrame     = s_q.sofFrame;
  assign sofStrobe    = s_q.sofStrobe;
  assign writeRefused = s_q.refused;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  sequence idx_wr_s;
    wr && addr == `MFI_OFS_INDEX;
  endsequence

  halted_write_a: assert property (@(posedge clk) disable iff (!rstn)
    idx_wr_s ##0 !haltedFlag ##0 !tick |=> s_q.index == $past(s_q.index) && writeRefused)
    else $error("index written while not halted");

  index_load_a: assert property (@(posedge clk) disable iff (!rstn)
    idx_wr_s ##0 haltedFlag |=> s_q.index == $past(wdata[13:0]))
    else $error("index write lost");

  index_step_a: assert property (@(posedge clk) disable iff (!rstn)
    tick && !wr |=> s_q.index == 14'($past(s_q.index) + 14'h0001) && sofStrobe)
    else $error("index did not advance");

  sof_frame_a: assert property (@(posedge clk) disable iff (!rstn)
    1'b1 |=> sofFrame == s_q.index[13:3])
    else $error("frame number mismatch");

  entry_low_a: assert property (@(posedge clk) disable iff (!rstn)
    entryAddr[1:0] == 2'b00 && entryAddr[31:12] == s_q.origin)
    else $error("entry address malformed");

  // the 256-entry list zeros the top two slot bits
  list_size_a: assert property (@(posedge clk) disable iff (!rstn)
    frameListSize == 2'h2 && $stable(frameListSize) |-> entryAddr[11:10] == 2'b00)
    else $error("slot too wide for list size");

  // upper half from segment only when wide
  upper_half_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(wideAddressingCapable) |-> entryAddr[63:32] == 32'h00000000)
    else $error("upper address without wide mode");

  index_read_a: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == `MFI_OFS_INDEX |=> rdata == {18'h00000, $past(s_q.index)})
    else $error("index read data wrong");

  origin_read_a: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == `MFI_OFS_ORIGIN |=> rdata == {$past(s_q.origin), 12'h000})
    else $error("origin read data wrong");

  // list entry held inside an eight-microframe group
  entry_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    tick && !wr && !walk.entryStep && $stable(frameListSize)
      |=> entryAddr[11:2] == $past(entryAddr[11:2]))
    else $error("list entry moved inside a group");

  // strobe only after a microframe tick
  strobe_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    sofStrobe == $past(tick))
    else $error("start-of-frame strobe without tick");

  // refusal only for an index write while not halted
  refuse_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    writeRefused == ($past(wr) && $past(addr) == `MFI_OFS_INDEX && !$past(haltedFlag)))
    else $error("write refusal pulse wrong");
endmodule
`default_nettype wire

/* dv/mfi_host_model.sv */
// model of the neighbouring command and status logic
// assumes runReq comes from the bench, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module mfi_host_model #(
  parameter int HALT_LAG = 4
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic runReq,
  output logic      runStop,
  output logic      haltedFlag
);
  int lag;

  always @(posedge clk) begin
    if (!rstn) begin
      runStop <= 1'b0;
      haltedFlag <= 1'b1;
      lag <= 0;
    end else if (runReq) begin
      runStop <= 1'b1;
      haltedFlag <= 1'b0;
      lag <= HALT_LAG;
    end else begin
      runStop <= 1'b0;
      if (lag > 0) begin
        lag <= lag - 1;
      end else begin
        haltedFlag <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* dv/mfi_frame_index_test.sv */
// bench for the microframe index block
// assumes a short microframe of CYC clocks
`timescale 1ns/1ps
`default_nettype none
`include "mfi_params.svh"
module mfi_frame_index_test;
  localparam int CYC = 8;
  logic        clk, rstn, wr, rd, runReq, runStop, haltedFlag;
  logic        wide, sofStrobe, writeRefused, refused;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  frameListSize;
  logic [63:0] entryAddr;
  logic [10:0] sofFrame;
  int          num_errors, cmp_count, n;

  mfi_frame_index #(.UFRAME_CYC(CYC)) i_dut (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .runStop(runStop),
    .haltedFlag(haltedFlag), .frameListSize(frameListSize),
    .wideAddressingCapable(wide), .entryAddr(entryAddr), .sofFrame(sofFrame),
    .sofStrobe(sofStrobe), .writeRefused(writeRefused));
  mfi_host_model i_host (.clk(clk), .rstn(rstn), .runReq(runReq),
    .runStop(runStop), .haltedFlag(haltedFlag));

  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1 refused = writeRefused;
  endtask
  task automatic rd32(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_tick;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (sofStrobe !== 1'b1 && n < 40);
  endtask
  function automatic logic [63:0] entry(logic [13:0] i, logic [1:0] s, logic w);
    logic [9:0] k;
    k = s == 2'h0 ? i[12:3] : s == 2'h1 ? {1'b0, i[11:3]} : {2'b0, i[10:3]};
    return {w ? 32'h00005A5A : 32'h0, 20'hABCDE, k, 2'b00};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // clock
  always #20 clk = ~clk;

  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    print_verdict;
  end

  // ----
  // tests
  // ----
  initial begin
    {clk, rstn, wr, rd, runReq, wide, frameListSize} = '0;
    {addr, wdata} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd32(`MFI_OFS_INDEX);
    chk(d, 0);
    rd32(`MFI_OFS_ORIGIN);
    chk(d, 0);
    rd32(8'h00);
    chk(d, 0);
    $display("test reset done");
    wr32(`MFI_OFS_ORIGIN, 32'hABCDE000);
    wr32(`MFI_OFS_SEGMENT, 32'h00005A5A);
    wr32(`MFI_OFS_INDEX, 32'h00003FFF);
    chk(refused, 0);
    rd32(`MFI_OFS_INDEX);
    chk(d, 32'h00003FFF);
    rd32(`MFI_OFS_ORIGIN);
    chk(d, 32'hABCDE000);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      frameListSize <= i[1:0];
      wide <= i[2];
      repeat (2) @(posedge clk);
      #1 chk(entryAddr, entry(14'h3FFF, i[1:0], i[2]));
      chk(sofFrame, 11'h7FF);
    end
    $display("test sizes done");
    @(posedge clk);
    frameListSize <= 2'h1;
    runReq <= 1'b1;
    wait_tick;
    chk(sofFrame, 0);
    chk(entryAddr, entry(14'h0, 2'h1, 1'b1));
    for (int j = 0; j < 8; j++) begin
      wait_tick;
      chk(n, CYC);
    end
    @(posedge clk);
    runReq <= 1'b0;
    wr32(`MFI_OFS_INDEX, 32'h00000055);
    chk(refused, 1);
    repeat (8) @(posedge clk);
    rd32(`MFI_OFS_INDEX);
    chk(d, 32'h00000008);
    chk(sofFrame, 11'h001);
    chk(entryAddr, entry(14'h8, 2'h1, 1'b1));
    $display("test run done");
    wr32(`MFI_OFS_INDEX, 32'h00000123);
    repeat (2) @(posedge clk);
    #1 chk(sofFrame, 11'h024);
    $display("test rewrite done");
    print_verdict;
  end
endmodule
`default_nettype wire
